// ==== design/rrc_map.svh ====
// Offsets-free constants for the reset and initialization controller
`ifndef RRC_MAP_SVH
`define RRC_MAP_SVH
`define RRC_CLK_PERIOD_NS 10
`define RRC_STAB_MAX_NS   15000
`define RRC_STAB_CYCLES   ((`RRC_STAB_MAX_NS) / (`RRC_CLK_PERIOD_NS))
`define RRC_CA_W          24
`define RRC_CS_W          4
`define RRC_CS_IDLE       4'hF
`define RRC_CKE_RESET     2'h0
`define RRC_ODT_RESET     2'h0
`define RRC_QUAD_DEFAULT  1'h0
`endif

// ==== design/rrc_pkg.sv ====
// Types shared by the reset and initialization controller
`include "rrc_map.svh"
package rrc_pkg;
  typedef enum logic [1:0] {
    RRC_ST_RESET,
    RRC_ST_BLOCKED,
    RRC_ST_STAB,
    RRC_ST_RUN
  } rrc_state_type;

  typedef struct packed {
    logic                    reset_n;
    logic                    clock_stable;
    logic                    four_select_mode_n;
    logic [`RRC_CS_W-1:0]    chip_select_inputs;
    logic                    clock_enable_input_0;
    logic                    clock_enable_input_1;
    logic [1:0]              termination_inputs;
    logic [`RRC_CA_W-1:0]    cmd_addr_inputs;
  } rrc_pins_in_type;

  typedef struct packed {
    logic [`RRC_CS_W-1:0]    chip_select_outputs;
    logic [1:0]              termination_outputs;
    logic                    side_a_clock_enable_out_0;
    logic                    side_a_clock_enable_out_1;
    logic                    side_b_clock_enable_out_0;
    logic                    side_b_clock_enable_out_1;
    logic [`RRC_CA_W-1:0]    cmd_addr_outputs;
  } rrc_pins_out_type;
endpackage

// ==== design/rrc_stab_timer.sv ====
// Stabilization interval counter started on reset release
`include "rrc_map.svh"
module rrc_stab_timer #(
  parameter int CYCLES = `RRC_STAB_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic start,
  output logic      expired
);
  import rrc_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          run_ff;
  logic          nxt_run;

  // Count down the interval, stop at zero
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    if (clear) begin
      nxt_cnt = '0;
      nxt_run = 1'b0;
    end else if (start) begin
      nxt_cnt = CW'(CYCLES - 1);
      nxt_run = 1'b1;
    end else if (run_ff && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CW'(1);
    end else begin
      nxt_run = 1'b0;
    end
  end

  // Register the counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

  assign expired = run_ff && (cnt_ff == '0);
endmodule

// ==== design/rrc_reset_ctrl.sv ====
// Reset, stabilization and output-state control of the clock driver
`include "rrc_map.svh"
// What this block and the controller driving it must do
// [R1] Controller holds reset low 200 us with stable power after power-up; the bench model holds it low at least 11 cycles.
// [R2] While reset is low, input receivers are disabled and their levels ignored.
// [R3] While reset is low, internal control registers return to defaults.
// [R4] In reset, four clock-enable outputs drive low; all other outputs float.
// [R5] While reset is low, device stays low power with termination removed.
// [R6] Before release, controller gives stable reference, clock, chip selects high.
// [R7] Controller holds both clock-enable inputs low through the stabilization interval.
// [R8] Forwarding starts only after release plus stabilization interval, at most 15 us.
// [R9] Controller always drives reset at a valid level once clock runs.
// [R10] Device is in reset state from power-up, outputs defined.
// [R11] Reset state is left only on a rising reset edge with stable clock.
// [R12] Reset entry clears state, floats outputs, clock enables go low.
// [R13] Chip-select top index is 1 normally and 3 in four-select mode.
// [R14] After release, termination outputs low until first clock edge, then follow.
// [R15] Controller asserts a soft reset for at least 100 ns.
// [R16] Stabilization is a cycle counter from release gating the forwarding path.
module rrc_reset_ctrl #(
  parameter int STAB_CYCLES = `RRC_STAB_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire rrc_pkg::rrc_pins_in_type  pins_in,
  output rrc_pkg::rrc_pins_out_type      pins_out,
  output rrc_pkg::rrc_pins_out_type      pins_oe,
  output logic                           forwarded_clock_outputs_en,
  output logic                           low_power,
  output logic                           termination_enable,
  output logic                           forwarding_active
);
  import rrc_pkg::*;

  // Synchroniser stages for every pin input
  rrc_pins_in_type sync1_ff;
  rrc_pins_in_type sync2_ff;
  rrc_pins_in_type nxt_sync1;
  rrc_pins_in_type nxt_sync2;

  // Sequencer state
  rrc_state_type   state_ff;
  rrc_state_type   nxt_state;
  logic            reset_prev_ff;
  logic            nxt_reset_prev;
  logic            quad_ff;
  logic            nxt_quad;
  logic            first_edge_ff;
  logic            nxt_first_edge;

  // Output registers
  rrc_pins_out_type out_ff;
  rrc_pins_out_type nxt_out;
  rrc_pins_out_type oe_ff;
  rrc_pins_out_type nxt_oe;

  logic            rise;
  logic            in_reset;
  logic            stab_start;
  logic            stab_done;

  // Mapping of chip selects by mode
  function automatic logic [`RRC_CS_W-1:0] map_cs(input logic quad, input logic [`RRC_CS_W-1:0] cs);
    logic [`RRC_CS_W-1:0] r;
    r = cs;
    if (!quad) begin
      r = {cs[1:0], cs[1:0]}; // R13
    end
    return r;
  endfunction

  // Exactly one selected chip select is low
  function automatic logic one_selected(input logic quad, input logic [`RRC_CS_W-1:0] cs);
    logic [`RRC_CS_W-1:0] act;
    int                   n;
    act = ~cs;
    if (!quad) begin
      act[3:2] = 2'h0; // R13
    end
    n = 0;
    for (int i = 0; i < `RRC_CS_W; i++) begin
      n = n + int'(act[i]);
    end
    return n == 1;
  endfunction

  // Two-flop synchronisers
  always_comb begin
    nxt_sync1 = pins_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign rise       = sync2_ff.reset_n && !reset_prev_ff;
  assign in_reset   = !sync2_ff.reset_n;
  assign stab_start = (state_ff == RRC_ST_RESET) && rise && sync2_ff.clock_stable;

  // Stabilization interval counter
  rrc_stab_timer #(
    .CYCLES (STAB_CYCLES)
  ) u_stab (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clear   (in_reset),
    .start   (stab_start),  // R16
    .expired (stab_done)
  );

  // Sequencer next state
  always_comb begin
    nxt_state      = state_ff;
    nxt_reset_prev = sync2_ff.reset_n;
    nxt_quad       = quad_ff;
    nxt_first_edge = first_edge_ff;
    if (in_reset) begin
      nxt_state      = RRC_ST_RESET;          // R12
      nxt_quad       = `RRC_QUAD_DEFAULT;     // R3
      nxt_first_edge = 1'b0;
    end else begin
      case (state_ff)
        RRC_ST_RESET: begin
          if (stab_start) begin
            nxt_state      = RRC_ST_STAB;     // R11
            nxt_quad       = !sync2_ff.four_select_mode_n;
          end else if (rise) begin
            nxt_state = RRC_ST_BLOCKED;       // R11
          end
        end
        RRC_ST_BLOCKED: begin
          nxt_state = RRC_ST_BLOCKED;         // R11
        end
        RRC_ST_STAB: begin
          nxt_first_edge = 1'b1;              // R14
          if (stab_done) begin
            nxt_state = RRC_ST_RUN;           // R8
          end
        end
        RRC_ST_RUN: begin
          nxt_state = RRC_ST_RUN;
        end
        default: begin
          nxt_state = RRC_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff      <= RRC_ST_RESET;          // R10
      reset_prev_ff <= 1'b0;
      quad_ff       <= `RRC_QUAD_DEFAULT;
      first_edge_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      reset_prev_ff <= nxt_reset_prev;
      quad_ff       <= nxt_quad;
      first_edge_ff <= nxt_first_edge;
    end
  end

  // Output values and enables per state
  always_comb begin
    nxt_out = out_ff;
    nxt_oe  = '0;
    nxt_oe.side_a_clock_enable_out_0 = 1'b1;
    nxt_oe.side_a_clock_enable_out_1 = 1'b1;
    nxt_oe.side_b_clock_enable_out_0 = 1'b1;
    nxt_oe.side_b_clock_enable_out_1 = 1'b1;
    if (in_reset || state_ff == RRC_ST_RESET || state_ff == RRC_ST_BLOCKED) begin
      nxt_out.chip_select_outputs       = `RRC_CS_IDLE;          // R2
      nxt_out.termination_outputs       = `RRC_ODT_RESET;
      {nxt_out.side_a_clock_enable_out_0, nxt_out.side_a_clock_enable_out_1} = `RRC_CKE_RESET; // R4
      {nxt_out.side_b_clock_enable_out_0, nxt_out.side_b_clock_enable_out_1} = `RRC_CKE_RESET; // R4
      nxt_out.cmd_addr_outputs          = '0;                    // R12
    end else if (state_ff == RRC_ST_STAB) begin
      nxt_oe                            = '1;
      nxt_out.chip_select_outputs       = `RRC_CS_IDLE;
      nxt_out.side_a_clock_enable_out_0 = 1'b0;
      nxt_out.side_a_clock_enable_out_1 = 1'b0;
      nxt_out.side_b_clock_enable_out_0 = 1'b0;
      nxt_out.side_b_clock_enable_out_1 = 1'b0;
      nxt_out.termination_outputs       = first_edge_ff ? sync2_ff.termination_inputs : `RRC_ODT_RESET; // R14
    end else begin
      nxt_oe                            = '1;
      nxt_out.termination_outputs       = sync2_ff.termination_inputs;
      nxt_out.side_a_clock_enable_out_0 = sync2_ff.clock_enable_input_0;
      nxt_out.side_b_clock_enable_out_0 = sync2_ff.clock_enable_input_0;
      nxt_out.side_a_clock_enable_out_1 = sync2_ff.clock_enable_input_1;
      nxt_out.side_b_clock_enable_out_1 = sync2_ff.clock_enable_input_1;
      nxt_out.chip_select_outputs       = `RRC_CS_IDLE;
      if (one_selected(quad_ff, sync2_ff.chip_select_inputs)) begin
        nxt_out.chip_select_outputs = map_cs(quad_ff, sync2_ff.chip_select_inputs); // R8
        nxt_out.cmd_addr_outputs    = sync2_ff.cmd_addr_inputs;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_ff <= '0;
      out_ff.chip_select_outputs <= `RRC_CS_IDLE;
      oe_ff  <= '0;
    end else begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
    end
  end

  // Clock enables are driven even before reset release
  always_comb begin
    pins_oe = oe_ff;
    pins_oe.side_a_clock_enable_out_0 = 1'b1; // R4
    pins_oe.side_a_clock_enable_out_1 = 1'b1;
    pins_oe.side_b_clock_enable_out_0 = 1'b1;
    pins_oe.side_b_clock_enable_out_1 = 1'b1;
  end

  assign pins_out                   = out_ff;
  assign forwarded_clock_outputs_en = (state_ff == RRC_ST_STAB) || (state_ff == RRC_ST_RUN);
  assign low_power                  = (state_ff == RRC_ST_RESET) || (state_ff == RRC_ST_BLOCKED); // R5
  assign termination_enable         = !low_power; // R5
  assign forwarding_active          = (state_ff == RRC_ST_RUN); // R16
endmodule

// ==== bench/rrc_ctrl_model.sv ====
// Controller model driving reset, select and command pins
module rrc_ctrl_model #(
  parameter int STAB = 20
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rel_req,
  input  wire logic                 stable,
  input  wire logic                 quad_n,
  input  wire logic [3:0]           cs,
  input  wire logic [1:0]           odt,
  input  wire logic [23:0]          ca,
  output rrc_pkg::rrc_pins_in_type  pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import rrc_pkg::*;
  int          hold  = 0;
  int          since = 0;
  logic        rel   = 1'b0;
  logic        go;
  logic [23:0] junk  = 24'h5A5A5A;
  // Reset pin held low a minimum time, scaled down
  always @(posedge clk_sys) begin
    junk  <= ~junk;
    hold  <= rel ? 0 : hold + 1;
    since <= rel ? since + 1 : 0;
    rel   <= rel_req && (rel || hold >= 10);
  end
  assign go = rel && since > STAB + 4;
  // Selects high until stabilization ends, enables low from release until then
  always_comb begin
    pins_in.reset_n              = rel;
    pins_in.clock_stable         = stable;
    pins_in.four_select_mode_n   = quad_n;
    pins_in.chip_select_inputs   = go ? cs : 4'hF;
    pins_in.clock_enable_input_0 = rel ? go : junk[0];
    pins_in.clock_enable_input_1 = rel ? go : junk[1];
    pins_in.termination_inputs   = rel ? odt : junk[3:2];
    pins_in.cmd_addr_inputs      = rel ? ca : junk;
  end
endmodule

// ==== bench/rrc_reset_ctrl_assertions.sv ====
// Port checker for the reset controller
module rrc_reset_chk #(
  parameter int STAB_CYCLES = 20
) (
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire rrc_pkg::rrc_pins_in_type  pins_in,
  input wire rrc_pkg::rrc_pins_out_type pins_out,
  input wire rrc_pkg::rrc_pins_out_type pins_oe,
  input wire logic                      forwarded_clock_outputs_en,
  input wire logic                      low_power,
  input wire logic                      termination_enable,
  input wire logic                      forwarding_active
);
  timeunit 1ns;
  timeprecision 1ps;
  import rrc_pkg::*;
  int         hi_ff;
  int         nxt_hi;
  logic [3:0] cs_p;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles the reset pin has been high
  always_comb nxt_hi = pins_in.reset_n ? hi_ff + 1 : 0;
  always_ff @(posedge clk_sys) hi_ff <= rst_n ? nxt_hi : 0;
  // Selects with the unused upper pair masked off in two-select mode
  always_ff @(posedge clk_sys) cs_p <= pins_in.chip_select_inputs | (pins_in.four_select_mode_n ? 4'hC : 4'h0);
  a_cke_low_reset: assert property ((!pins_in.reset_n)[*4] |->
    pins_out[27:24] == 4'h0 && pins_oe[27:24] == 4'hF) else $error("enables not low in reset");
  a_float_reset: assert property ((!pins_in.reset_n)[*4] |->
    {pins_oe[33:28], pins_oe[23:0]} == 30'h0) else $error("outputs not floated");
  a_low_power_reset: assert property ((!pins_in.reset_n)[*4] |-> low_power &&
    !termination_enable && !forwarding_active && !forwarded_clock_outputs_en) else $error("not low power");
  a_cs_stab: assert property (forwarded_clock_outputs_en && !forwarding_active |->
    pins_out[33:30] == 4'hF && pins_out[27:24] == 4'h0) else $error("selects pass in stab");
  a_odt_first: assert property ($rose(forwarded_clock_outputs_en) |=>
    pins_out[29:28] == 2'h0 ##1
    pins_out[29:28] == $past(pins_in.termination_inputs, 3)) else $error("termination early");
  a_fwd_window: assert property ($rose(forwarding_active) |->
    hi_ff >= STAB_CYCLES && hi_ff <= STAB_CYCLES + 8) else $error("stab length wrong");
  a_ca_follow: assert property (forwarding_active[*5] ##0 $countones(~$past(cs_p, 2)) == 1 |->
    pins_out[23:0] == $past(pins_in.cmd_addr_inputs, 3)) else $error("ca not forwarded");
  a_cs_pair: assert property (forwarding_active[*5] ##0 $countones(~$past(cs_p, 2)) == 1 |->
    pins_out[33:30] == ($past(pins_in.four_select_mode_n, 3) ? {2{$past(cs_p[1:0], 2)}}
    : $past(cs_p, 2))) else $error("select mapping wrong");
  // Main scenarios
  c_run: cover property ($rose(forwarding_active));
  c_stab: cover property ($rose(forwarded_clock_outputs_en));
  c_exit: cover property (forwarding_active ##1 !forwarding_active);
endmodule
bind rrc_reset_ctrl rrc_reset_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe), .low_power(low_power),
  .forwarded_clock_outputs_en(forwarded_clock_outputs_en), .termination_enable(termination_enable),
  .forwarding_active(forwarding_active));

// ==== bench/tb.sv ====
// Self-checking bench for the reset controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rrc_pkg::*;
  localparam int STAB = 20;
  logic             clk_sys = 1'b0;
  logic             rst_n   = 1'b0;
  logic             rel_req = 1'b0;
  logic             stable  = 1'b1;
  logic             quad_n  = 1'b1;
  logic [3:0]       cs      = 4'hF;
  logic [1:0]       odt     = 2'h0;
  logic [23:0]      ca      = 24'h000000;
  rrc_pins_in_type  pins_in;
  rrc_pins_out_type pins_out;
  rrc_pins_out_type pins_oe;
  logic             fce;
  logic             lp;
  logic             te;
  logic             fa;
  int               n_errors     = 0;
  int               total_checks = 0;
  rrc_ctrl_model #(.STAB(STAB)) CTRL (.clk_sys(clk_sys), .rel_req(rel_req), .stable(stable),
    .quad_n(quad_n), .cs(cs), .odt(odt), .ca(ca), .pins_in(pins_in));
  rrc_reset_ctrl #(.STAB_CYCLES(STAB)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .pins_in(pins_in),
    .pins_out(pins_out), .pins_oe(pins_oe), .forwarded_clock_outputs_en(fce), .low_power(lp),
    .termination_enable(te), .forwarding_active(fa));
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reset state after the pin goes low
  task automatic t_idle();
    tick(6);
    chk("out", 34'h3C0000000, pins_out);
    chk("oe", 34'h00F000000, pins_oe);
    chk("power", 4'h8, {lp, te, fce, fa});
  endtask
  // Release, stabilization, forwarding and refusal
  task automatic t_init(input logic q);
    int n;
    n = 0;
    @(posedge clk_sys);
    quad_n  <= q;
    stable  <= 1'b1;
    rel_req <= 1'b1;
    while (pins_in.reset_n !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    if (n == 50) begin
      n_errors++;
      $display("Error reset pin expected 1 seen 0");
      finish_test();
    end
    n = 0;
    while (fa !== 1'b1 && n < 100) begin
      chk("stab cs", 4'hF, pins_out[33:30]);
      chk("stab cke", 4'h0, pins_out[27:24]);
      tick(1);
      n++;
    end
    chk("stab len", 1'b1, n >= STAB && n <= STAB + 8);
    if (n == 100) finish_test();
    @(posedge clk_sys);
    cs  <= 4'hE;
    ca  <= 24'hA5C3F0;
    odt <= 2'h2;
    tick(4);
    chk("cs out", q ? 4'hA : 4'hE, pins_out[33:30]);
    chk("ca out", 24'hA5C3F0, pins_out[23:0]);
    chk("odt out", 2'h2, pins_out[29:28]);
    chk("cke out", 4'hF, pins_out[27:24]);
    chk("oe run", 34'h3FFFFFFFF, pins_oe);
    chk("power run", 4'h7, {lp, te, fce, fa});
    @(posedge clk_sys);
    cs <= 4'hC;
    ca <= 24'h123456;
    tick(4);
    chk("cs none", 4'hF, pins_out[33:30]);
    chk("ca hold", 24'hA5C3F0, pins_out[23:0]);
  endtask
  // Reset entry while forwarding
  task automatic t_entry();
    @(posedge clk_sys);
    rel_req <= 1'b0;
    cs      <= 4'hF;
    t_idle();
  endtask
  // Release without a stable clock stays in reset
  task automatic t_blocked();
    @(posedge clk_sys);
    stable  <= 1'b0;
    rel_req <= 1'b1;
    tick(40);
    chk("blocked", 4'h8, {lp, te, fce, fa});
    chk("blocked out", 34'h3C0000000, pins_out);
    chk("blocked oe", 34'h00F000000, pins_oe);
    @(posedge clk_sys);
    rel_req <= 1'b0;
    tick(12);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_idle();
    t_init(1'b1);
    t_entry();
    t_blocked();
    t_init(1'b0);
    t_entry();
    finish_test();
  end
endmodule
